// ### verilog/afr_readout.sv
// sample readout: data window, status word, interrupt arming, clock/gain port
// Function
// - top two bits pick clock/gain destination
// - payload is low thirty bits
// - gain pair index in 26:23, bit30
// - vsb path reads next sample, any data area address
// - vsb data area 0x8000 bytes, pops
// - status read disarms vsb interrupts
// - status 26:24 show backplane slot address
// - status 28 high when data present
// - status 29 low at half full
// - half full raises enabled interrupts
// - status 30 low when fifo full
// - status 31 shows pending vsb interrupt
// - host polls status after interrupt
// - arm read plus enable bit sources interrupt
// - vme data at offset zero, path 0/2
// - packed: even high half, odd low
// - unpacked: sample in 31:8, zeros below
// - front port drives 24 bits, low eight zero
// - oscillator data shifted out lsb first
// - vme enable clear after reset
`timescale 1ns/1ps
module afr_readout (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire afr_pkg::afr_acc_t i_acc,
   input wire logic i_acc_vsb,
   output logic [31:0] o_acc_rdata,
   output logic o_acc_ack,
   input wire logic [2:0] i_output_path_select,
   input wire logic i_vsb_irq_enable_bit,
   input wire logic i_vme_irq_enable_bit,
   input wire logic i_packed_mode,
   input wire logic i_fifo_reset_bit,
   input wire logic [2:0] i_global_addr,
   input wire afr_pkg::afr_smp_t i_smp,
   output logic o_smp_ready,
   input wire logic i_fpdp_suspend,
   output logic [31:0] o_fpdp_data,
   output logic o_fpdp_dvalid,
   output logic o_vme_irq,
   output logic o_vsb_irq,
   output logic o_osc_sdata,
   output logic o_osc_sclk,
   output logic o_osc_smp_sel,
   output logic o_osc_strb_sel,
   output logic o_gain_stb,
   output logic [3:0] o_gain_pair,
   output logic [22:0] o_gain_value,
   output logic o_osc_busy
);
   typedef enum logic [1:0] {
      OSC_IDLE,
      OSC_LOW,
      OSC_HIGH
   } afr_osc_t;

   // path decode, used for readout and draining
   function automatic logic is_vsb_path(input logic [2:0] p);
      is_vsb_path = (p == afr_pkg::PATH_VSB_A) || (p == afr_pkg::PATH_VSB_B);
   endfunction
   function automatic logic is_vme_path(input logic [2:0] p);
      is_vme_path = (p == afr_pkg::PATH_VME_A) || (p == afr_pkg::PATH_VME_B);
   endfunction
   function automatic logic is_fp_path(input logic [2:0] p);
      is_fp_path = (p == afr_pkg::PATH_FP_MST) || (p == afr_pkg::PATH_FP_SLV);
   endfunction

   // synchronisers for pins
   logic [2:0] gaddr_s1_q; // first stage, read only by second
   logic [2:0] gaddr_q; // slot address, stable
   logic susp_s1_q; // first stage
   logic susp_q; // suspend, synchronised
   // packing
   logic [15:0] even_half_q; // even channel waiting for its partner
   logic [31:0] pack_word; // word offered to the fifo
   logic pack_valid; // offer strobe
   // fifo wiring
   logic fifo_in_ready; // room in the fifo
   logic fifo_out_valid; // head present
   logic [31:0] fifo_head; // head word
   logic fifo_pop; // drain this cycle
   logic [5:0] fifo_cnt; // occupancy
   logic half_full; // at least half
   logic fifo_full; // no room
   logic smp_push; // sample word accepted this edge
   logic [5:0] cnt_next; // occupancy after this edge
   // decode
   logic in_data_area; // inside 0x8000 byte window
   logic rd_vsb_data; // data window read, vsb path
   logic rd_vme_data; // data read, vme path
   logic rd_state; // status word read
   logic rd_arm; // arm location read
   logic wr_cg; // clock/gain write
   logic fp_take; // front port takes a word
   // interrupt state
   logic vsb_armed_q; // set by arm read
   logic vsb_irq_pending_q; // pending flag
   logic vme_en_q; // registered vme enable
   // serial oscillator port
   afr_osc_t osc_st_q; // shifter state
   logic [26:0] osc_shift_q; // bits still to go, lsb first
   logic [4:0] osc_left_q; // bits remaining
   logic [7:0] osc_tim_q; // half-period timer
   logic [31:0] rdata_d; // read answer, next value

   // pin synchronisers: two flops before any use
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         gaddr_s1_q <= 3'h0;
         gaddr_q <= 3'h0;
         susp_s1_q <= 1'h0;
         susp_q <= 1'h0;
      end else begin
         gaddr_s1_q <= i_global_addr;
         gaddr_q <= gaddr_s1_q;
         susp_s1_q <= i_fpdp_suspend;
         susp_q <= susp_s1_q;
      end
   end

   // word building from the converter stream
   always_comb begin
      if (i_packed_mode) begin
         pack_word = {even_half_q, i_smp.data[23:8]};
         pack_valid = i_smp.valid && i_smp.odd;
      end else begin
         pack_word = {i_smp.data, afr_pkg::RST_ZERO8};
         pack_valid = i_smp.valid;
      end
   end

   // even channel holding register for packed mode
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         even_half_q <= 16'h0000;
      end else if (i_smp.valid && !i_smp.odd && o_smp_ready) begin
         even_half_q <= i_smp.data[23:8];
      end
   end

   // source stalls on full fifo; the sample is kept by the source
   // accept only on the registered ready the source also sees
   assign smp_push = pack_valid && o_smp_ready;
   assign cnt_next = fifo_cnt + 6'(smp_push) - 6'(fifo_pop && fifo_out_valid);

   // ready from a flop: room left once this edge's push and pop are done
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_smp_ready <= 1'h0;
      end else if (i_fifo_reset_bit) begin
         o_smp_ready <= 1'h1; // clear empties the fifo; a sample offered meanwhile is lost
      end else begin
         o_smp_ready <= (cnt_next != 6'(afr_pkg::FIFO_DEPTH));
      end
   end

   afr_fifo #(
      .WIDTH(afr_pkg::FIFO_WIDTH),
      .DEPTH(afr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_clear(i_fifo_reset_bit),
      .i_in_valid(smp_push),
      .i_in_data(pack_word),
      .o_in_ready(fifo_in_ready),
      .o_out_valid(fifo_out_valid),
      .o_out_data(fifo_head),
      .i_out_ready(fifo_pop),
      .o_count(fifo_cnt)
   );

   assign half_full = (fifo_cnt >= afr_pkg::FIFO_HALF);
   assign fifo_full = !fifo_in_ready;

   // address decode; any offset in the window pops, address ignored
   assign in_data_area = (i_acc.addr < afr_pkg::DATA_AREA_BASE + afr_pkg::DATA_AREA_SIZE);
   assign rd_vsb_data = i_acc.rd && i_acc_vsb && in_data_area && is_vsb_path(i_output_path_select);
   assign rd_vme_data = i_acc.rd && !i_acc_vsb && (i_acc.addr == afr_pkg::OFS_VME_DATA)
      && is_vme_path(i_output_path_select);
   assign rd_state = i_acc.rd && i_acc_vsb && (i_acc.addr == afr_pkg::OFS_STATE_WORD);
   assign rd_arm = i_acc.rd && i_acc_vsb && (i_acc.addr == afr_pkg::OFS_IRQ_ARM);
   assign wr_cg = i_acc.wr && (i_acc.addr == afr_pkg::OFS_CLOCK_GAIN);
   assign fp_take = is_fp_path(i_output_path_select) && !susp_q;
   // reads of an empty fifo return zero and pop nothing
   assign fifo_pop = rd_vsb_data || rd_vme_data || fp_take;

   // read answer mux
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (rd_vsb_data || rd_vme_data) begin
         rdata_d = fifo_out_valid ? fifo_head : 32'h0000_0000;
      end else if (rd_state) begin
         rdata_d[afr_pkg::ST_GADDR_LSB +: 3] = gaddr_q;
         rdata_d[afr_pkg::ST_NOT_EMPTY] = fifo_out_valid;
         rdata_d[afr_pkg::ST_HALF_N] = !half_full;
         rdata_d[afr_pkg::ST_FULL_N] = !fifo_full;
         rdata_d[afr_pkg::ST_IRQ_PEND] = vsb_irq_pending_q;
      end
   end

   // bus answer one cycle after the strobe
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_acc_rdata <= 32'h0000_0000;
         o_acc_ack <= 1'h0;
      end else begin
         o_acc_rdata <= rdata_d;
         o_acc_ack <= i_acc.rd || i_acc.wr;
      end
   end

   // front port: upper 24 bits only, low byte held low
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_fpdp_data <= 32'h0000_0000;
         o_fpdp_dvalid <= 1'h0;
      end else begin
         o_fpdp_dvalid <= fp_take && fifo_out_valid;
         if (fp_take && fifo_out_valid) begin
            o_fpdp_data <= {fifo_head[31:8], afr_pkg::RST_ZERO8};
         end
      end
   end

   // vsb arming: arm read sets, status read clears, set wins
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         vsb_armed_q <= 1'h0;
      end else if (rd_arm) begin
         vsb_armed_q <= 1'h1;
      end else if (rd_state) begin
         vsb_armed_q <= 1'h0;
      end
   end

   // vsb pending flag; a new event beats the clearing status read
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         vsb_irq_pending_q <= 1'h0;
         o_vsb_irq <= 1'h0;
      end else begin
         if (vsb_armed_q && i_vsb_irq_enable_bit && half_full) begin
            vsb_irq_pending_q <= 1'h1;
         end else if (rd_state) begin
            vsb_irq_pending_q <= 1'h0;
         end
         o_vsb_irq <= vsb_irq_pending_q;
      end
   end

   // vme interrupt follows half full while enabled; enable off after reset
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         vme_en_q <= 1'h0;
         o_vme_irq <= 1'h0;
      end else begin
         vme_en_q <= i_vme_irq_enable_bit;
         o_vme_irq <= vme_en_q && half_full;
      end
   end

   // gain path: pair index and value strobed out on bit30 writes
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_gain_stb <= 1'h0;
         o_gain_pair <= 4'h0;
         o_gain_value <= 23'h000000;
      end else begin
         o_gain_stb <= wr_cg && i_acc.wdata[afr_pkg::CG_SEL_LO];
         if (wr_cg && i_acc.wdata[afr_pkg::CG_SEL_LO]) begin
            o_gain_pair <= i_acc.wdata[afr_pkg::CG_PAIR_LSB +: 4];
            o_gain_value <= i_acc.wdata[22:0];
         end
      end
   end

   // oscillator shifter; writes while busy are dropped, the host
   // spacing between words keeps that from happening in practice
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         osc_st_q <= OSC_IDLE;
         osc_shift_q <= 27'h0000000;
         osc_left_q <= 5'h00;
         osc_tim_q <= 8'h00;
         o_osc_sdata <= 1'h0;
         o_osc_sclk <= 1'h0;
         o_osc_smp_sel <= 1'h0;
         o_osc_strb_sel <= 1'h0;
         o_osc_busy <= 1'h0;
      end else begin
         case (osc_st_q)
            OSC_IDLE: begin
               o_osc_sclk <= 1'h0;
               // start only for clock targets, bit30 clear
               if (wr_cg && !i_acc.wdata[afr_pkg::CG_SEL_LO]) begin
                  osc_shift_q <= i_acc.wdata[26:0];
                  // length is base plus the excess field
                  osc_left_q <= afr_pkg::CG_BASE_LEN
                     + {2'h0, i_acc.wdata[afr_pkg::CG_LEN_LSB +: 3]};
                  o_osc_smp_sel <= !i_acc.wdata[afr_pkg::CG_SEL_HI];
                  o_osc_strb_sel <= i_acc.wdata[afr_pkg::CG_SEL_HI];
                  o_osc_busy <= 1'h1;
                  osc_tim_q <= 8'h00;
                  osc_st_q <= OSC_LOW;
               end
            end
            OSC_LOW: begin
               // data set up while clock is low
               o_osc_sclk <= 1'h0;
               o_osc_sdata <= osc_shift_q[0];
               if (osc_tim_q == 8'(afr_pkg::OSC_HALF_CYC - 1)) begin
                  osc_tim_q <= 8'h00;
                  osc_st_q <= OSC_HIGH;
               end else begin
                  osc_tim_q <= osc_tim_q + 8'h01;
               end
            end
            OSC_HIGH: begin
               o_osc_sclk <= 1'h1;
               if (osc_tim_q == 8'(afr_pkg::OSC_HALF_CYC - 1)) begin
                  osc_tim_q <= 8'h00;
                  osc_shift_q <= {1'h0, osc_shift_q[26:1]};
                  if (osc_left_q == 5'h01) begin
                     osc_left_q <= 5'h00;
                     o_osc_busy <= 1'h0;
                     o_osc_smp_sel <= 1'h0;
                     o_osc_strb_sel <= 1'h0;
                     osc_st_q <= OSC_IDLE;
                  end else begin
                     osc_left_q <= osc_left_q - 5'h01;
                     osc_st_q <= OSC_LOW;
                  end
               end else begin
                  osc_tim_q <= osc_tim_q + 8'h01;
               end
            end
            default: begin
               osc_st_q <= OSC_IDLE;
            end
         endcase
      end
   end
endmodule

// ### verilog/afr_pkg.sv
// shared constants and carrier types for the sample readout block
package afr_pkg;
   // register bus window, byte offsets inside the board window
   localparam logic [15:0] DATA_AREA_BASE = 16'h0000;
   localparam logic [15:0] DATA_AREA_SIZE = 16'h8000;
   localparam logic [15:0] OFS_STATE_WORD = 16'h8000;
   localparam logic [15:0] OFS_IRQ_ARM = 16'h8004;
   localparam logic [15:0] OFS_CLOCK_GAIN = 16'h8008;
   localparam logic [15:0] OFS_VME_DATA = 16'h0000;
   // status word bit positions
   localparam int ST_GADDR_LSB = 24;
   localparam int ST_NOT_EMPTY = 28;
   localparam int ST_HALF_N = 29;
   localparam int ST_FULL_N = 30;
   localparam int ST_IRQ_PEND = 31;
   // clock/gain word fields
   localparam int CG_SEL_HI = 31;
   localparam int CG_SEL_LO = 30;
   localparam int CG_LEN_LSB = 27;
   localparam int CG_PAIR_LSB = 23;
   localparam logic [4:0] CG_BASE_LEN = 5'h16;
   // output path codes
   localparam logic [2:0] PATH_VME_A = 3'h0;
   localparam logic [2:0] PATH_VSB_A = 3'h1;
   localparam logic [2:0] PATH_VME_B = 3'h2;
   localparam logic [2:0] PATH_FP_MST = 3'h4;
   localparam logic [2:0] PATH_FP_SLV = 3'h5;
   localparam logic [2:0] PATH_VSB_B = 3'h7;
   // fifo geometry
   localparam int FIFO_WIDTH = 32;
   localparam int FIFO_DEPTH = 32;
   localparam logic [5:0] FIFO_HALF = 6'h10;
   // serial oscillator bit time
   localparam int CLK_PERIOD_NS = 25;
   localparam int OSC_HALF_NS = 100;
   localparam int OSC_HALF_CYC = (OSC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] RST_ZERO8 = 8'h00;
   // register access request from the bus front end
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [31:0] wdata;
   } afr_acc_t;
   // sample from the converter side
   typedef struct packed {
      logic valid;
      logic odd;
      logic [23:0] data;
   } afr_smp_t;
endpackage

// ### verilog/afr_fifo.sv
// sample fifo with valid/ready on both sides
`timescale 1ns/1ps
module afr_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_clear,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready,
   output logic [$clog2(DEPTH):0] o_count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH]; // storage, flip-flops
   logic [AW-1:0] wptr_q; // write index
   logic [AW-1:0] rptr_q; // read index
   logic [AW:0] cnt_q; // occupancy
   logic push; // accepted write
   logic pop; // accepted read

   assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data = mem_q[rptr_q];
   assign o_count = cnt_q;
   assign push = i_in_valid && o_in_ready;
   assign pop = i_out_ready && o_out_valid;

   // storage writes, no reset needed on data
   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem_q[wptr_q] <= i_in_data;
      end
   end

   // pointers and count
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b || i_clear) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= wptr_q + AW'(1);
         end
         if (pop) begin
            rptr_q <= rptr_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ### test/afr_readout_chk.sv
// assertion checker bound to the readout block ports
`timescale 1ns/1ps
module afr_readout_chk (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire afr_pkg::afr_acc_t i_acc,
   input wire logic i_acc_vsb,
   input wire logic [31:0] o_acc_rdata,
   input wire logic o_acc_ack,
   input wire logic [2:0] i_output_path_select,
   input wire logic i_vsb_irq_enable_bit,
   input wire logic i_vme_irq_enable_bit,
   input wire logic i_packed_mode,
   input wire logic [2:0] i_global_addr,
   input wire logic [31:0] o_fpdp_data,
   input wire logic o_fpdp_dvalid,
   input wire logic o_vme_irq,
   input wire logic o_vsb_irq,
   input wire logic o_osc_sdata,
   input wire logic o_osc_sclk,
   input wire logic o_osc_smp_sel,
   input wire logic o_osc_strb_sel,
   input wire logic o_osc_busy
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);
   // status word read on the vsb side
   sequence stat_rd;
      i_acc.rd && i_acc_vsb && i_acc.addr == afr_pkg::OFS_STATE_WORD;
   endsequence
   // data window read in vsb path, unpacked
   sequence unp_rd;
      i_acc.rd && i_acc_vsb && !i_acc.addr[15] && !i_packed_mode &&
         (i_output_path_select == 3'h1 || i_output_path_select == 3'h7);
   endsequence
   // rest of one serial high phase, then low
   sequence hi_phase;
      o_osc_sclk [*3] ##1 !o_osc_sclk;
   endsequence
   ack_follows_a: assert property ((i_acc.rd || i_acc.wr) |=> o_acc_ack)
      else $error("no ack after access");
   slot_field_a: assert property ($stable(i_global_addr) [*4] ##0 stat_rd |=>
      o_acc_rdata[26:24] == $past(i_global_addr) && !o_acc_rdata[27] && o_acc_rdata[23:0] == 24'h0)
      else $error("status slot field wrong");
   unp_zero_a: assert property (unp_rd |=> o_acc_rdata[7:0] == 8'h00)
      else $error("unpacked low byte not zero");
   fp_low_a: assert property (o_fpdp_dvalid |-> o_fpdp_data[7:0] == 8'h00 &&
      ($past(i_output_path_select) == 3'h4 || $past(i_output_path_select) == 3'h5))
      else $error("front port word wrong");
   vme_off_a: assert property (!i_vme_irq_enable_bit [*3] |-> !o_vme_irq)
      else $error("vme irq while disabled");
   vsb_src_a: assert property ($rose(o_vsb_irq) |-> $past(i_vsb_irq_enable_bit) ||
      $past(i_vsb_irq_enable_bit, 2))
      else $error("vsb irq without enable");
   sclk_high_a: assert property ($rose(o_osc_sclk) |=> hi_phase)
      else $error("serial high phase length");
   sdata_hold_a: assert property (o_osc_sclk |-> $stable(o_osc_sdata))
      else $error("serial data moved in high phase");
   one_sel_a: assert property (o_osc_busy |-> o_osc_smp_sel != o_osc_strb_sel)
      else $error("oscillator selects clash");
endmodule
bind afr_readout afr_readout_chk chk_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_acc(i_acc), .i_acc_vsb(i_acc_vsb),
   .o_acc_rdata(o_acc_rdata), .o_acc_ack(o_acc_ack), .i_output_path_select(i_output_path_select),
   .i_vsb_irq_enable_bit(i_vsb_irq_enable_bit), .i_vme_irq_enable_bit(i_vme_irq_enable_bit),
   .i_packed_mode(i_packed_mode), .i_global_addr(i_global_addr), .o_fpdp_data(o_fpdp_data),
   .o_fpdp_dvalid(o_fpdp_dvalid), .o_vme_irq(o_vme_irq), .o_vsb_irq(o_vsb_irq), .o_osc_sdata(o_osc_sdata),
   .o_osc_sclk(o_osc_sclk), .o_osc_smp_sel(o_osc_smp_sel), .o_osc_strb_sel(o_osc_strb_sel),
   .o_osc_busy(o_osc_busy));

// ### test/afr_host.sv
// bus master model: one-cycle access strobes, waits for the ack
`timescale 1ns/1ps
module afr_host (
   input wire logic i_mclk,
   input wire logic i_ack,
   input wire logic [31:0] i_rdata,
   output afr_pkg::afr_acc_t o_acc,
   output logic o_vsb
);
   // idle bus from time zero
   initial begin
      o_acc = '0;
      o_vsb = 1'b0;
   end
   // read or write, never both; ok low when no answer comes
   task automatic xfer(input logic rd, input logic vsb, input logic [15:0] a, input logic [31:0] wd,
         output logic [31:0] rdat, output logic ok);
      int n;
      ok = 1'b0;
      rdat = '0;
      @(negedge i_mclk);
      o_acc = '{rd: rd, wr: !rd, addr: a, wdata: wd};
      o_vsb = vsb;
      @(negedge i_mclk);
      // strobe is one cycle wide by the bus contract
      o_acc = '0;
      for (n = 0; n < 4 && !ok; n++) begin
         if (i_ack === 1'b1) begin
            ok = 1'b1;
            rdat = i_rdata;
         end else begin
            @(negedge i_mclk);
         end
      end
   endtask
endmodule

// ### test/test_adc_fifo_host_readout.sv
// self-checking bench for the sample readout block
`timescale 1ns/1ps
module test_adc_fifo_host_readout;
   logic i_mclk, i_rst_b, acc_vsb, ack, pk, clr, susp, ven, ben, rdy, dval;
   logic virq, birq, sd, sck, ssel, tsel, gstb, busy;
   logic [31:0] rdata, fdata, r;
   logic [2:0] path;
   logic [3:0] gpair;
   logic [22:0] gval;
   logic [26:0] gcap;
   logic [31:0] fq [$];
   afr_pkg::afr_acc_t acc;
   afr_pkg::afr_smp_t smp;
   int err_total, tests_run, gn;
   logic [2:0] ga; // backplane slot pins
   localparam logic [15:0] ST = afr_pkg::OFS_STATE_WORD;
   afr_readout dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_acc(acc), .i_acc_vsb(acc_vsb), .o_acc_rdata(rdata),
      .o_acc_ack(ack), .i_output_path_select(path), .i_vsb_irq_enable_bit(ben), .i_vme_irq_enable_bit(ven),
      .i_packed_mode(pk), .i_fifo_reset_bit(clr), .i_global_addr(ga), .i_smp(smp), .o_smp_ready(rdy),
      .i_fpdp_suspend(susp), .o_fpdp_data(fdata), .o_fpdp_dvalid(dval), .o_vme_irq(virq), .o_vsb_irq(birq),
      .o_osc_sdata(sd), .o_osc_sclk(sck), .o_osc_smp_sel(ssel), .o_osc_strb_sel(tsel), .o_gain_stb(gstb),
      .o_gain_pair(gpair), .o_gain_value(gval), .o_osc_busy(busy));
   afr_host host_u (.i_mclk(i_mclk), .i_ack(ack), .i_rdata(rdata), .o_acc(acc), .o_vsb(acc_vsb));
   // 40 mhz clock
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   // gain strobes and front port words, caught as they pass
   always @(negedge i_mclk) begin
      if (gstb === 1'b1) begin
         gn = gn + 1;
         gcap = {gpair, gval};
      end
      if (dval === 1'b1) fq.push_back(fdata);
   end
   task automatic summarize;
      if (err_total == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   // one access; a lost answer ends the run
   task automatic bus(input logic rd, input logic vsb, input logic [15:0] a, input logic [31:0] wd);
      logic ok;
      host_u.xfer(rd, vsb, a, wd, r, ok);
      if (!ok) begin
         err_total++;
         summarize();
      end
   endtask
   // expected status word for a fill level
   function automatic logic [31:0] stw(input int cnt, input logic pend);
      return {pend, cnt < 32, cnt < 16, cnt > 0, 1'b0, ga, 24'h0};
   endfunction
   // one converter sample, held until the fifo has room
   task automatic push(input logic odd, input logic [23:0] d);
      int k;
      @(negedge i_mclk); // keeps the valid drop and the next raise apart
      for (k = 0; k < 50 && rdy !== 1'b1; k++) @(negedge i_mclk);
      if (k == 50) begin
         err_total++;
         summarize();
      end
      smp = '{valid: 1'b1, odd: odd, data: d};
      @(negedge i_mclk);
      smp.valid = 1'b0;
   endtask
   task automatic fclr;
      clr = 1'b1;
      @(negedge i_mclk);
      clr = 1'b0;
      @(negedge i_mclk);
   endtask
   task automatic t_reset;
      bus(1, 1, ST, 0);
      chk("status", r, stw(0, 0));
      chk("vme irq", virq, 0);
      ga = 3'h2;
      repeat (3) @(negedge i_mclk);
      bus(1, 1, ST, 0);
      chk("slot", r, stw(0, 0));
   endtask
   // odd addresses in the window, wrong-path read pops nothing
   task automatic t_unpacked;
      logic [15:0] ad [3] = '{16'h0000, 16'h7ffc, 16'h1235};
      path = 3'h1;
      for (int i = 0; i < 3; i++) push(i[0], {8'h11 * i[7:0], 16'hc35a});
      bus(1, 1, ST, 0);
      chk("status", r, stw(3, 0));
      bus(1, 0, afr_pkg::OFS_VME_DATA, 0);
      chk("wrong path", r, 0);
      for (int i = 0; i < 3; i++) begin
         bus(1, 1, ad[i], 0);
         chk("vsb data", r, {8'h11 * i[7:0], 16'hc35a, 8'h00});
      end
      bus(1, 1, ST, 0);
      chk("status", r, stw(0, 0));
   endtask
   // even then odd channel, vme paths 0 and 2
   task automatic t_packed;
      pk = 1'b1;
      for (int i = 0; i < 2; i++) begin
         path = {1'b0, i[0], 1'b0};
         push(0, {8'h21 + i[7:0], 16'h1357});
         push(1, {8'h43 + i[7:0], 16'h9bdf});
         bus(1, 0, afr_pkg::OFS_VME_DATA, 0);
         chk("packed", r, {8'h21 + i[7:0], 8'h13, 8'h43 + i[7:0], 8'h9b});
      end
      pk = 1'b0;
   endtask
   // fill to the half mark and to full
   task automatic t_levels;
      path = 3'h1;
      ven = 1'b1;
      for (int i = 1; i <= 32; i++) begin
         push(0, i[23:0]);
         if (i == 15) chk("vme irq", virq, 0);
         if (i == 15 || i == 16 || i == 32) begin
            bus(1, 1, ST, 0);
            chk("status", r, stw(i, 0));
         end
      end
      chk("vme irq", virq, 1);
      chk("ready", rdy, 0);
      ven = 1'b0;
      repeat (3) @(negedge i_mclk);
      chk("vme irq", virq, 0);
      ven = 1'b1;
      repeat (3) @(negedge i_mclk);
      chk("vme irq", virq, 1);
      // board reset with the fifo full and the enable still set
      i_rst_b = 1'b0;
      repeat (3) @(negedge i_mclk);
      chk("vme irq", virq, 0);
      i_rst_b = 1'b1;
      @(negedge i_mclk);
      bus(1, 1, ST, 0);
      chk("status", r, stw(0, 0));
      ven = 1'b0;
      fclr();
   endtask
   // arm by read, raise at half, status reads disarm
   task automatic t_vsb_irq;
      int k;
      ben = 1'b1;
      bus(1, 1, afr_pkg::OFS_IRQ_ARM, 0);
      for (int i = 0; i < 16; i++) push(1, 24'h0);
      for (k = 0; k < 10 && birq !== 1'b1; k++) @(negedge i_mclk);
      chk("vsb irq", birq, 1);
      bus(1, 1, ST, 0);
      chk("status", r, stw(16, 1));
      bus(1, 1, ST, 0);
      repeat (3) @(negedge i_mclk);
      chk("vsb irq", birq, 0);
      bus(1, 1, ST, 0);
      chk("status", r, stw(16, 0));
      ben = 1'b0;
      fclr();
   endtask
   // oscillator word: length 22 plus bits 29:27, lsb first
   task automatic t_osc(input logic [31:0] w);
      logic [31:0] got;
      int k, b, n;
      logic p;
      got = '0;
      b = 0;
      p = 1'b0;
      n = 22 + w[29:27];
      bus(0, 1, afr_pkg::OFS_CLOCK_GAIN, w);
      chk("smp sel", ssel, !w[31]);
      chk("strb sel", tsel, w[31]);
      for (k = 0; k < 1000 && busy === 1'b1; k++) begin
         if (sck === 1'b1 && !p) begin
            got[b] = sd;
            b++;
         end
         p = sck;
         @(negedge i_mclk);
      end
      chk("bit count", b, n);
      chk("serial word", got, w & ((32'h1 << n) - 32'h1));
      repeat (20) @(negedge i_mclk);
   endtask
   // bit 30 wins over bit 31
   task automatic t_gain;
      chk("no gain", gn, 0);
      bus(0, 0, afr_pkg::OFS_CLOCK_GAIN, 32'hc485a5a5);
      repeat (3) @(negedge i_mclk);
      chk("gain count", gn, 1);
      chk("gain data", gcap, {4'h9, 23'h05a5a5});
      chk("osc idle", busy, 0);
   endtask
   // front port stalls on suspend, then drains
   task automatic t_fpdp;
      path = 3'h4;
      push(0, 24'h8badf0);
      push(1, 24'h13579b);
      repeat (5) @(negedge i_mclk);
      chk("stalled", fq.size(), 0);
      susp = 1'b0;
      repeat (8) @(negedge i_mclk);
      chk("words", fq.size(), 2);
      chk("word0", fq[0], 32'h8badf000);
      chk("word1", fq[1], 32'h13579b00);
   endtask
   initial begin
      i_rst_b = 1'b0;
      path = 3'h0;
      pk = 1'b0;
      clr = 1'b0;
      susp = 1'b1;
      ven = 1'b0;
      ben = 1'b0;
      ga = 3'h5;
      smp = '0;
      err_total = 0;
      tests_run = 0;
      gn = 0;
      repeat (8) @(negedge i_mclk);
      i_rst_b = 1'b1;
      @(negedge i_mclk);
      t_reset();
      t_unpacked();
      t_packed();
      t_levels();
      t_vsb_irq();
      t_osc(32'h0dead5a5);
      t_osc(32'h8255aa53);
      t_gain();
      t_fpdp();
      summarize();
   end
endmodule
